// file: ifeb_regs.svh
// Register map, field masks and reset values of the flag and enable bank.
`ifndef IFEB_REGS_SVH
`define IFEB_REGS_SVH
`define IFEB_OFF_FLAGS5 8'h00
`define IFEB_OFF_FLAGS6 8'h04
`define IFEB_OFF_FLAGS7 8'h08
`define IFEB_OFF_FLAGS8 8'h0c
`define IFEB_OFF_EN0 8'h10
`define IFEB_OFF_ISTAT 8'h14
`define IFEB_OFF_IMASK 8'h18
`define IFEB_MASK_FLAGS5 16'hffce
`define IFEB_MASK_FLAGS6 16'h001f
`define IFEB_MASK_FLAGS7 16'hffc0
`define IFEB_MASK_FLAGS8 16'h7fdf
`define IFEB_MASK_EN0 16'hffff
`define IFEB_BIT_USB 6
`define IFEB_BIT_UART3_RX 2
`define IFEB_BIT_UART3_ERR 1
`define IFEB_BIT_DEBUGGER 14
`define IFEB_RESET16 16'h0000
`define IFEB_RESET32 32'h0000_0000
`endif

// file: ifeb_pkg.sv
// Types shared by the flag and enable bank.
package ifeb_pkg;
  typedef logic [3:0][15:0] ifeb_banks_t;
  typedef struct packed {
    ifeb_banks_t flags;
    logic [15:0] en;
    logic [3:0] istat;
    logic [3:0] imask;
    logic [31:0] rdata;
  } ifeb_state_t;
endpackage

// file: ifeb_bank.sv
// Interrupt flag banks 5 to 8 and enable bank 0 behind an APB slave.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "ifeb_regs.svh"
module ifeb_bank #(
  parameter bit HAS_USB = 1'b1,
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral event pulses, one word per flag bank 5 to 8.
  input wire ifeb_pkg::ifeb_banks_t src_events,
  // Enables of banks 5 to 8 and flags of bank 0, held elsewhere.
  input wire ifeb_pkg::ifeb_banks_t enables_in,
  input wire logic [15:0] flags0_in,
  // Requests toward priority arbitration.
  output ifeb_pkg::ifeb_banks_t req_fwd,
  output logic [15:0] req_fwd0,
  // Summary interrupt.
  output logic irq
);

  initial begin
    if (ADDR_W < 5 || ADDR_W > 32) begin
      $error("ADDR_W must lie between 5 and 32.");
    end
  end

  ifeb_pkg::ifeb_state_t st;
  ifeb_pkg::ifeb_state_t next_st;

  // Returns the word index 0 to 6, or 7 for an unmapped address.
  function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    lo = 8'(a);
    if (a[1:0] != 2'b00 || (a >> 8) != '0 || lo > `IFEB_OFF_IMASK) begin
      return 3'd7;
    end
    return lo[4:2];
  endfunction

  function automatic logic [15:0] impl_mask(input int b);
    case (b)
      0: return HAS_USB ? `IFEB_MASK_FLAGS5 :
          (`IFEB_MASK_FLAGS5 & ~(16'h0001 << `IFEB_BIT_USB));
      1: return `IFEB_MASK_FLAGS6;
      2: return `IFEB_MASK_FLAGS7;
      3: return `IFEB_MASK_FLAGS8;
      default: return `IFEB_RESET16;
    endcase
  endfunction

  logic [2:0] idx;
  logic bus_wr;
  logic bus_rd;
  logic [3:0] ev_any;

  assign idx = decode(paddr);
  assign bus_wr = psel && penable && pwrite && idx != 3'd7;
  assign bus_rd = psel && !penable && !pwrite;

  always_comb begin
    next_st = st;
    for (int b = 0; b < 4; b++) begin
      // A bus write and an event in one cycle: the event is kept.
      if (bus_wr && idx == 3'(b)) begin
        next_st.flags[b] = pwdata[15:0] | src_events[b];
      end else begin
        next_st.flags[b] = st.flags[b] | src_events[b];
      end
      next_st.flags[b] = next_st.flags[b] & impl_mask(b);
      ev_any[b] = |(src_events[b] & impl_mask(b));
    end
    if (bus_wr && idx == 3'd4) begin
      next_st.en = pwdata[15:0] & `IFEB_MASK_EN0;
    end
    if (bus_wr && idx == 3'd5) begin
      next_st.istat = st.istat & ~pwdata[3:0];
    end
    next_st.istat = next_st.istat | ev_any;
    if (bus_wr && idx == 3'd6) begin
      next_st.imask = pwdata[3:0];
    end
    if (bus_rd) begin
      case (idx)
        3'd0, 3'd1, 3'd2, 3'd3:
          next_st.rdata = {16'h0000, st.flags[idx[1:0]]};
        3'd4: next_st.rdata = {16'h0000, st.en};
        3'd5: next_st.rdata = {28'h000_0000, st.istat};
        3'd6: next_st.rdata = {28'h000_0000, st.imask};
        default: next_st.rdata = `IFEB_RESET32;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      req_fwd[b] = st.flags[b] & enables_in[b];
    end
  end

  assign req_fwd0 = flags0_in & st.en;
  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && idx == 3'd7;
  assign irq = |(st.istat & st.imask);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_flag_sticky: assert property (
    !bus_wr |=> (st.flags[0] & $past(st.flags[0])) == $past(st.flags[0]))
    else $error("A set flag fell without a bus write.");
  chk_event_sets: assert property (
    src_events[1][0] |=> st.flags[1][0])
    else $error("Event did not set its flag.");
  chk_flag_quiet: assert property (
    !bus_wr && src_events[2] == 16'h0000
    |=> (st.flags[2] & ~$past(st.flags[2])) == 16'h0000)
    else $error("Flag set with no event.");
  chk_fwd_both: assert property (
    (enables_in[3][`IFEB_BIT_DEBUGGER] && st.flags[3][`IFEB_BIT_DEBUGGER])
    |-> req_fwd[3][`IFEB_BIT_DEBUGGER])
    else $error("Enabled pending request not forwarded.");
  chk_block_off: assert property (
    (enables_in[1] == 16'h0000) |-> req_fwd[1] == 16'h0000)
    else $error("Disabled request forwarded.");
  chk_unimpl_zero: assert property (
    (st.flags[1] & ~`IFEB_MASK_FLAGS6) == 16'h0000 &&
    (st.flags[2] & ~`IFEB_MASK_FLAGS7) == 16'h0000)
    else $error("Unimplemented flag bit set.");
  chk_write_takes: assert property (
    bus_wr && idx == 3'd1 |=> st.flags[1] ==
    (($past(pwdata[15:0]) | $past(src_events[1])) & `IFEB_MASK_FLAGS6))
    else $error("Flag write not taken.");
  chk_uart3_bits: assert property (
    src_events[0][`IFEB_BIT_UART3_RX] && !src_events[0][0]
    |=> st.flags[0][`IFEB_BIT_UART3_RX] && !st.flags[0][0])
    else $error("UART3 receive flag misplaced.");
  chk_usb_inert: assert property (
    !HAS_USB |-> !st.flags[0][`IFEB_BIT_USB])
    else $error("USB flag set without USB.");
  chk_dma8_pos: assert property (
    src_events[2][6] |=> st.flags[2][6] && st.flags[2][5:0] == 6'h00)
    else $error("DMA8 flag misplaced.");
  chk_bank8_holes: assert property (
    !st.flags[3][15] && !st.flags[3][5])
    else $error("Bank 8 hole bit set.");
  chk_enable_write: assert property (
    bus_wr && idx == 3'd4 |=> st.en == $past(pwdata[15:0]))
    else $error("Enable write not taken.");
  chk_fwd_needs: assert property (
    |req_fwd0 |-> |(flags0_in & st.en))
    else $error("Request forwarded without flag and enable.");
  chk_irq_level: assert property (
    ev_any[0] && st.imask[0] && !(bus_wr && idx == 3'd6) |=> irq)
    else $error("Masked-in event raised no interrupt.");

endmodule // ifeb_bank

// file: ifeb_src.sv
// Peripheral event source model that pulses one flag bank.
`timescale 1ns/1ps
module ifeb_src (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Request from the bench.
  input wire logic fire,
  input wire logic [1:0] bank,
  input wire logic [15:0] pat,
  // Event pulses toward the bank.
  output ifeb_pkg::ifeb_banks_t src_events
);
  // Events last one cycle, as a held level would keep re-setting flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_events <= '0;
    end else begin
      src_events <= '0;
      if (fire) begin
        src_events[bank] <= pat;
      end
    end
  end
endmodule // ifeb_src

// file: tb.sv
// Self-checking bench for the flag and enable bank.
`timescale 1ns/1ps
`include "ifeb_regs.svh"
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, irq, e, fire = 0;
  logic [1:0] bank = '0;
  logic [15:0] pat = '0, flags0_in = '0, req_fwd0;
  ifeb_pkg::ifeb_banks_t src_events, req_fwd, enables_in = '0;
  int fail_count = 0, checks_done = 0, cyc = 0;
  logic [15:0] msk [4] = '{`IFEB_MASK_FLAGS5, `IFEB_MASK_FLAGS6,
    `IFEB_MASK_FLAGS7, `IFEB_MASK_FLAGS8};
  ifeb_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_events(src_events), .enables_in(enables_in),
    .flags0_in(flags0_in), .req_fwd(req_fwd), .req_fwd0(req_fwd0),
    .irq(irq));
  ifeb_src src (.pclk(pclk), .presetn(presetn), .fire(fire),
    .bank(bank), .pat(pat), .src_events(src_events));
  initial forever #2.5 pclk = ~pclk;
  task automatic chk(string n, logic [31:0] g, logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 7; i++) begin
      apb(0, 8'(4 * i), '0);
      chk("reset", r, '0);
    end
    apb(1, 8'h1c, 32'hffff_ffff);
    chk("unmapped", e, 1);
    apb(0, 8'h02, '0);
    chk("misaligned", e, 1);
  endtask
  task automatic t_rw;
    for (int i = 0; i < 4; i++) begin
      apb(1, 8'(4 * i), 32'hffff_ffff);
      apb(0, 8'(4 * i), '0);
      chk("flag rw", r, msk[i]);
      apb(1, 8'(4 * i), '0);
      apb(0, 8'(4 * i), '0);
      chk("flag clr", r, '0);
    end
    apb(1, `IFEB_OFF_EN0, 32'hffff_ffff);
    apb(0, `IFEB_OFF_EN0, '0);
    chk("en0", r, 32'h0000_ffff);
  endtask
  task automatic t_evt;
    apb(1, `IFEB_OFF_IMASK, 32'h0000_000e);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      fire <= 1;
      bank <= 2'(i);
      pat <= 16'hffff;
      @(posedge pclk);
      fire <= 0;
      apb(0, 8'(4 * i), '0);
      chk("event", r, msk[i]);
      chk("blocked", req_fwd[i], '0);
      chk("irq", irq, i != 0);
      apb(0, `IFEB_OFF_ISTAT, '0);
      chk("istat", r, 32'(1 << i));
      enables_in[i] <= 16'h5555;
      apb(1, `IFEB_OFF_ISTAT, 32'(1 << i));
      chk("fwd", req_fwd[i], msk[i] & 16'h5555);
      apb(1, 8'(4 * i), '0);
      // Let the write land before looking at what it drives.
      @(negedge pclk);
      chk("irq clr", irq, 0);
      chk("unfwd", req_fwd[i], '0);
    end
    flags0_in <= 16'ha5a5;
    apb(1, `IFEB_OFF_EN0, 32'h0000_0ff0);
    @(negedge pclk);
    chk("fwd0", req_fwd0, 16'h05a0);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Guards against a hung handshake.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_rw();
    t_evt();
    summarize();
  end
endmodule // tb
